/* hw/e1_ts16_pkg.sv */
// Constants and types shared by the timeslot-16 framer block
package e1_ts16_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_TX_EXTRA = 8'h04;
  localparam logic [7:0] OFS_IDLE_0_7 = 8'h08;
  localparam logic [7:0] OFS_IDLE_8_15 = 8'h0C;
  localparam logic [7:0] OFS_IDLE_16_23 = 8'h10;
  localparam logic [7:0] OFS_IDLE_24_31 = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // ----------------------------------------------------------------
  // Control fields and reset values
  // ----------------------------------------------------------------
  localparam int CTL_CCS = 0;
  localparam int CTL_XREG = 1;
  localparam int CTL_ODD = 2;
  localparam int CTL_HDB3 = 3;
  localparam logic [3:0] CONTROL_RESET = 4'h0;
  localparam logic [7:0] TX_EXTRA_RESET = 8'h00;
  localparam logic [31:0] IDLE_RESET = 32'h0000_0000;
  localparam int TXR_ALARM = 2;
  // ----------------------------------------------------------------
  // Line format, latencies and bus response codes
  // ----------------------------------------------------------------
  localparam logic [7:0] IDLE_CODE = 8'hD5;
  localparam logic [4:0] SLOT_FAS = 5'h00;
  localparam logic [4:0] SLOT_SIG = 5'h10;
  localparam logic [4:0] SLOT_LAST = 5'h1F;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_NIBBLE = 3'h4;
  localparam logic [3:0] FRAME_LAST = 4'hF;
  localparam int TX_LATENCY = 5;
  localparam int RX_LATENCY = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Synchroniser lanes
  // ----------------------------------------------------------------
  localparam int NSYNC = 8;
  localparam int I_TXCLK = 0;
  localparam int I_TXSER = 1;
  localparam int I_TXEXT = 2;
  localparam int I_TXFS = 3;
  localparam int I_TXMFS = 4;
  localparam int I_RXCLK = 5;
  localparam int I_RXPOS = 6;
  localparam int I_RXNEG = 7;

  typedef struct packed {
    logic [3:0] frame;
    logic [4:0] slot;
    logic [2:0] bitn;
  } pos_t;
endpackage

/* hw/e1_ts16_framer.sv */
// Timeslot-16 insertion, idle forcing and frame timing for an E1 framer
//
// Contract
// [R1] CAS, register source: extra bits come from extra register bits 0,1,3.
// [R2] CAS, pin source: extra bits sampled on extra-bit pin at their times.
// [R3] CCS: timeslot 16 passes serial input untouched, nothing inserted.
// [R4] Software writes zero to extra register bits 7..4, ignores on read.
// [R5] Set idle bit replaces whole timeslot with 11010101.
// [R6] Idle bit k across four registers maps to timeslot k.
// [R7] Timeslots 0 and 16 are never idle-forced.
// [R8] Multiframe sync rising edge sets multiframe; multiframe output shows it.
// [R9] Frame sync rising edge sets frame position; align output shows it.
// [R10] Sync inputs held low: free-running alignment, still reported.
// [R11] Align output marks even frames, or odd frames when parity set.
// [R12] Syncs rise one bit early; multiframe output follows either rise.
// [R13] Transmit align output changes only on true frame boundaries.
// [R14] Serial input reaches line outputs five line clocks later.
// [R15] Rx signaling: frame 0 slot 15, frame 1 slot 17, n: n-1, n+16.
// [R16] Rx signaling only in low nibble, A..D in bits 5..8.
// [R17] Rx signaling output idle in timeslots 0 and 16.
// [R18] Rx data on serial output six clocks later, HDB3 decoded if enabled.
// [R19] Rx frame and multiframe syncs rise one bit before boundaries.
// [R20] Rx align output changes on true frame boundaries.
// [R21] Rx multiframe syncs fall with the rx frame sync fall.
// [R22] CAS multiframe may start on any frame; CRC4 on an align frame.
// [R23] CAS frame 0 slot 16: 0000, extra bit, alarm, two extra bits.
// [R24] Alarm bit of extra register drives bit 6 of slot 16 frame 0.
`timescale 1ns/1ns
module e1_ts16_framer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [e1_ts16_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [e1_ts16_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic txLineClock,
  input wire logic txSerialIn,
  input wire logic txExtraBitIn,
  input wire logic txFrameSyncIn,
  input wire logic txMultiframeSyncIn,
  output logic txLinePos,
  output logic txLineNeg,
  output logic txMultiframeOut,
  output logic txAlignFrameOut,
  input wire logic rxLineClock,
  input wire logic rxLinePos,
  input wire logic rxLineNeg,
  output logic rxSerialOut,
  output logic rxChanSignalingOut,
  output logic rxFrameSyncOut,
  output logic rxCasMfSyncOut,
  output logic rxCrcMfSyncOut,
  output logic rxAlignFrameOut
);
  import e1_ts16_pkg::*;

  typedef struct packed {
    logic [NSYNC-1:0] syncA;
    logic [NSYNC-1:0] syncB;
    logic txClkPrev;
    logic rxClkPrev;
    logic txFsPrev;
    logic txMfsPrev;
    pos_t txPos;
    logic [TX_LATENCY-1:0] txPipe;
    logic amiNeg;
    logic txPos1;
    logic txNeg1;
    logic txMf;
    logic txAf;
    pos_t rxPos;
    logic [RX_LATENCY-1:0] rxPipe;
    logic rxLastPos;
    logic rxSer;
    logic rx_chan_signaling_out;
    logic rxFs;
    logic rxCasMf;
    logic rxCrcMf;
    logic rxAf;
    logic [7:0] ts16Cur;
    logic [7:0] ts16Prev;
    logic [3:0] ctrl;
    logic [7:0] transmit_extra_bits;
    logic [31:0] idle;
    logic awHave;
    logic wHave;
    logic [AXI_AW-1:0] awAddr;
    logic [7:0] wByte;
    logic wLane;
    logic awRdy;
    logic wRdy;
    logic bVal;
    logic [1:0] bResp;
    logic arRdy;
    logic rVal;
    logic [1:0] rResp;
    logic [31:0] rData;
  } state_t;

  state_t st;
  state_t next_st;
  logic txEdge;
  logic rxEdge;
  logic fsRise;
  logic mfRise;
  logic txBit;
  logic viol;
  logic rxMark;
  pos_t txNp;
  pos_t rxNp;

  function automatic pos_t incPos(input pos_t p);
    pos_t q;
    q = p;
    q.bitn = p.bitn + 3'h1;
    if (p.bitn == BIT_LAST) begin
      q.slot = p.slot + 5'h01;
      if (p.slot == SLOT_LAST) begin
        q.frame = p.frame + 4'h1;
      end
    end
    return q;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.syncA = {rxLineNeg, rxLinePos, rxLineClock, txMultiframeSyncIn,
      txFrameSyncIn, txExtraBitIn, txSerialIn, txLineClock};
    next_st.syncB = st.syncA;
    next_st.txClkPrev = st.syncB[I_TXCLK];
    next_st.rxClkPrev = st.syncB[I_RXCLK];
    txEdge = st.syncB[I_TXCLK] & ~st.txClkPrev;
    rxEdge = st.syncB[I_RXCLK] & ~st.rxClkPrev;
    fsRise = st.syncB[I_TXFS] & ~st.txFsPrev;
    mfRise = st.syncB[I_TXMFS] & ~st.txMfsPrev;
    // With syncs held low the counter simply wraps on its own
    txNp = incPos(st.txPos); // [R10]
    if (fsRise | mfRise) begin
      // Sync arrives one bit early: this bit closes the frame
      txNp.slot = SLOT_LAST; // [R9] [R12]
      txNp.bitn = BIT_LAST;
    end
    if (mfRise) begin
      txNp.frame = FRAME_LAST; // [R8]
    end
    txBit = st.syncB[I_TXSER];
    if (txNp.slot == SLOT_SIG) begin
      if (!st.ctrl[CTL_CCS] && txNp.frame == 4'h0) begin // [R3]
        if (txNp.bitn < BIT_NIBBLE) begin
          txBit = 1'b0; // [R23]
        end else if (st.ctrl[CTL_XREG] || txNp.bitn == 3'h5) begin
          txBit = st.transmit_extra_bits[3'h7 - txNp.bitn]; // [R1] [R24]
        end else begin
          txBit = st.syncB[I_TXEXT]; // [R2]
        end
      end
    end else if (txNp.slot != SLOT_FAS && st.idle[txNp.slot]) begin
      txBit = IDLE_CODE[3'h7 - txNp.bitn]; // [R5] [R6] [R7]
    end
    if (txEdge) begin
      next_st.txFsPrev = st.syncB[I_TXFS];
      next_st.txMfsPrev = st.syncB[I_TXMFS];
      next_st.txPos = txNp;
      next_st.txPipe = {st.txPipe[TX_LATENCY-2:0], txBit};
      // Alternate mark polarity keeps the line free of DC
      next_st.txPos1 = st.txPipe[TX_LATENCY-1] & ~st.amiNeg; // [R14]
      next_st.txNeg1 = st.txPipe[TX_LATENCY-1] & st.amiNeg;
      if (st.txPipe[TX_LATENCY-1]) begin
        next_st.amiNeg = ~st.amiNeg;
      end
      next_st.txMf = mfRise | fsRise | (txNp.frame == 4'h0); // [R12]
      if (txNp.slot == SLOT_FAS && txNp.bitn == 3'h0) begin
        next_st.txAf = txNp.frame[0] == st.ctrl[CTL_ODD]; // [R11] [R13]
      end
    end
    // Receive side
    rxMark = st.syncB[I_RXPOS] | st.syncB[I_RXNEG];
    viol = st.ctrl[CTL_HDB3] & rxMark &
      (st.syncB[I_RXPOS] == st.rxLastPos);
    rxNp = incPos(st.rxPos);
    if (rxEdge) begin
      if (rxMark) begin
        next_st.rxLastPos = st.syncB[I_RXPOS];
      end
      next_st.rxPipe = {st.rxPipe[RX_LATENCY-2:0], rxMark & ~viol};
      if (viol) begin
        // Violation also cancels the balancing pulse three bits back
        next_st.rxPipe[3] = 1'b0; // [R18]
      end
      next_st.rxSer = st.rxPipe[RX_LATENCY-1]; // [R18]
      next_st.rxPos = rxNp;
      if (rxNp.slot == SLOT_SIG) begin
        next_st.ts16Cur = {st.ts16Cur[6:0], st.rxPipe[RX_LATENCY-1]};
      end
      next_st.rx_chan_signaling_out = 1'b0; // [R17]
      if (rxNp.bitn >= BIT_NIBBLE) begin // [R16]
        if (rxNp.slot == {1'b1, rxNp.frame} && rxNp.frame != 4'h0) begin
          next_st.rx_chan_signaling_out = st.ts16Cur[3'h7 - rxNp.bitn]; // [R15]
        end else if (rxNp.slot != SLOT_FAS && rxNp.slot < SLOT_SIG &&
            ((rxNp.frame == 4'h0 && rxNp.slot == 5'h0F) ||
            (rxNp.frame > 4'h1 && {1'b0, rxNp.frame} == rxNp.slot + 5'h01)))
            begin
          // Earlier channel sits in the high nibble of the previous slot 16
          next_st.rx_chan_signaling_out = st.ts16Prev[3'h7 - (rxNp.bitn - BIT_NIBBLE)];
        end
      end
      next_st.rxFs = rxNp.slot == SLOT_LAST && rxNp.bitn == BIT_LAST; // [R19]
      next_st.rxCasMf = next_st.rxFs && rxNp.frame == FRAME_LAST; // [R21]
      // CRC4 multiframe opens on an align frame, so odd parity shifts it
      next_st.rxCrcMf = next_st.rxFs &&
        rxNp.frame == (st.ctrl[CTL_ODD] ? 4'h0 : FRAME_LAST); // [R22]
      if (rxNp.slot == SLOT_FAS && rxNp.bitn == 3'h0) begin
        next_st.ts16Prev = st.ts16Cur;
        next_st.rxAf = rxNp.frame[0] == st.ctrl[CTL_ODD]; // [R20]
      end
    end
    // Register bus: write channel
    if (awvalid && st.awRdy) begin
      next_st.awHave = 1'b1;
      next_st.awAddr = awaddr;
    end
    if (wvalid && st.wRdy) begin
      next_st.wHave = 1'b1;
      next_st.wByte = wdata[7:0];
      next_st.wLane = wstrb[0];
    end
    if (st.bVal && bready) begin
      next_st.bVal = 1'b0;
    end
    if (next_st.awHave && next_st.wHave && !st.bVal) begin
      next_st.awHave = 1'b0;
      next_st.wHave = 1'b0;
      next_st.bVal = 1'b1;
      next_st.bResp = RESP_OKAY;
      unique case (next_st.awAddr)
        OFS_CONTROL: if (next_st.wLane) next_st.ctrl = next_st.wByte[3:0];
        OFS_TX_EXTRA: if (next_st.wLane) next_st.transmit_extra_bits = next_st.wByte;
        OFS_IDLE_0_7: if (next_st.wLane) next_st.idle[7:0] = next_st.wByte;
        OFS_IDLE_8_15: if (next_st.wLane) next_st.idle[15:8] = next_st.wByte;
        OFS_IDLE_16_23:
          if (next_st.wLane) next_st.idle[23:16] = next_st.wByte;
        OFS_IDLE_24_31:
          if (next_st.wLane) next_st.idle[31:24] = next_st.wByte;
        OFS_STATUS: next_st.bResp = RESP_OKAY;
        default: next_st.bResp = RESP_SLVERR;
      endcase
    end
    // Register bus: read channel
    if (st.rVal && rready) begin
      next_st.rVal = 1'b0;
    end
    if (arvalid && st.arRdy) begin
      next_st.rVal = 1'b1;
      next_st.rResp = RESP_OKAY;
      unique case (araddr)
        OFS_CONTROL: next_st.rData = {28'h0, st.ctrl};
        OFS_TX_EXTRA: next_st.rData = {24'h0, st.transmit_extra_bits};
        OFS_IDLE_0_7: next_st.rData = {24'h0, st.idle[7:0]};
        OFS_IDLE_8_15: next_st.rData = {24'h0, st.idle[15:8]};
        OFS_IDLE_16_23: next_st.rData = {24'h0, st.idle[23:16]};
        OFS_IDLE_24_31: next_st.rData = {24'h0, st.idle[31:24]};
        OFS_STATUS: next_st.rData = {8'h0, st.rxPos, st.txPos};
        default: begin
          next_st.rData = 32'h0000_0000;
          next_st.rResp = RESP_SLVERR;
        end
      endcase
    end
    next_st.awRdy = !next_st.awHave && !next_st.bVal;
    next_st.wRdy = !next_st.wHave && !next_st.bVal;
    next_st.arRdy = !next_st.rVal;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
      st.ctrl <= CONTROL_RESET;
      st.transmit_extra_bits <= TX_EXTRA_RESET;
      st.idle <= IDLE_RESET;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  assign awready = st.awRdy;
  assign wready = st.wRdy;
  assign bvalid = st.bVal;
  assign bresp = st.bResp;
  assign arready = st.arRdy;
  assign rvalid = st.rVal;
  assign rresp = st.rResp;
  assign rdata = st.rData;
  assign txLinePos = st.txPos1;
  assign txLineNeg = st.txNeg1;
  assign txMultiframeOut = st.txMf;
  assign txAlignFrameOut = st.txAf;
  assign rxSerialOut = st.rxSer;
  assign rxChanSignalingOut = st.rx_chan_signaling_out;
  assign rxFrameSyncOut = st.rxFs;
  assign rxCasMfSyncOut = st.rxCasMf;
  assign rxCrcMfSyncOut = st.rxCrcMf;
  assign rxAlignFrameOut = st.rxAf;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence txSlot16F0;
    txEdge && !st.ctrl[CTL_CCS] && txNp.slot == SLOT_SIG &&
      txNp.frame == 4'h0;
  endsequence
  sequence fsSeen;
    txEdge && clkEn && fsRise && !mfRise;
  endsequence

  chk_extra_reg_src: assert property ( // [R1]
    txSlot16F0 and (st.ctrl[CTL_XREG] && txNp.bitn == 3'h4)
      |-> txBit == st.transmit_extra_bits[3])
    else $error("extra bit one not from register");
  chk_extra_pin_src: assert property ( // [R2]
    txSlot16F0 and (!st.ctrl[CTL_XREG] && txNp.bitn == 3'h7)
      |-> txBit == st.syncB[I_TXEXT])
    else $error("extra bit three not from pin");
  chk_ccs_pass: assert property ( // [R3]
    txEdge && st.ctrl[CTL_CCS] && txNp.slot == SLOT_SIG
      |-> txBit == st.syncB[I_TXSER])
    else $error("slot 16 altered in CCS mode");
  chk_idle_force: assert property ( // [R5]
    txEdge && txNp.slot != SLOT_FAS && txNp.slot != SLOT_SIG &&
      st.idle[txNp.slot] |-> txBit == IDLE_CODE[3'h7 - txNp.bitn])
    else $error("idle code not forced");
  chk_idle_skip: assert property ( // [R7]
    txEdge && txNp.slot == SLOT_FAS |-> txBit == st.syncB[I_TXSER])
    else $error("slot 0 altered");
  chk_align_word: assert property ( // [R23]
    txSlot16F0 and (txNp.bitn < BIT_NIBBLE) |-> !txBit)
    else $error("multiframe word not zero");
  chk_alarm_bit: assert property ( // [R24]
    txSlot16F0 and (txNp.bitn == 3'h5) |-> txBit == st.transmit_extra_bits[TXR_ALARM])
    else $error("alarm bit wrong");
  chk_frame_sync: assert property ( // [R9]
    fsSeen |=> st.txPos.slot == SLOT_LAST && st.txPos.bitn == BIT_LAST
      && st.txMf)
    else $error("frame sync not taken");
  chk_tx_af_edge: assert property ( // [R13]
    $changed(st.txAf) |-> st.txPos.slot == 5'h00 && st.txPos.bitn == 3'h0)
    else $error("tx align changed mid frame");
  chk_rx_fs_early: assert property ( // [R19]
    $rose(st.rxFs) |-> st.rxPos.slot == SLOT_LAST &&
      st.rxPos.bitn == BIT_LAST)
    else $error("rx frame sync misplaced");
  chk_rx_mf_fall: assert property ( // [R21]
    $fell(st.rxFs) |-> !st.rxCasMf && !st.rxCrcMf)
    else $error("rx multiframe sync outlived frame sync");
  chk_rsd_nibble: assert property ( // [R16] [R17]
    st.rx_chan_signaling_out |-> st.rxPos.bitn >= BIT_NIBBLE &&
      st.rxPos.slot != SLOT_FAS && st.rxPos.slot != SLOT_SIG)
    else $error("signaling outside low nibble");
endmodule

/* verification/e1_line_model.sv */
// Line-side model: line clocks, tx syncs, AMI capture and rx stream
`timescale 1ns/1ns
module e1_line_model (
  input wire logic start,
  output logic txLineClock,
  output logic txSerialIn,
  output logic txExtraBitIn,
  output logic txFrameSyncIn,
  output logic txMultiframeSyncIn,
  input wire logic txLinePos,
  input wire logic txLineNeg,
  input wire logic txMultiframeOut,
  input wire logic txAlignFrameOut,
  output logic rxLineClock,
  output logic rxLinePos,
  output logic rxLineNeg,
  input wire logic rxSerialOut,
  input wire logic rxFrameSyncOut,
  input wire logic rxCasMfSyncOut,
  input wire logic rxCrcMfSyncOut,
  input wire logic rxChanSignalingOut,
  input wire logic rxAlignFrameOut,
  output logic [7:0] cap [160],
  output logic [4:0] flags,
  output int passes,
  output int rxErr,
  output int rxCmp
);
  localparam int S = 16;
  int r, b, q, p, t, n, gap;
  logic [6:0] hist;
  logic [9:0] lfsr;
  logic mark, prevFs;
  int pos, fr, sl, bt;
  logic [7:0] sig, prevSig;
  logic e, prevAf;
  // ----------------------------------------------------------------
  // Transmit side
  // ----------------------------------------------------------------
  initial begin
    {txLineClock, txSerialIn, txFrameSyncIn, txMultiframeSyncIn} = 4'h0;
    txExtraBitIn = 1'b1;
    passes = 0;
    flags = 5'h00;
    r = 0;
    wait (start);
    // Keep line edges off the system clock edges
    #7;
    forever begin
      #200 txLineClock = 1'b1;
      r++;
      #200 txLineClock = 1'b0;
      // One bit early, then held low so the framer free-runs
      txMultiframeSyncIn = (r >= S - 1) && (r < S + 3);
      // A lone frame sync at the end of frame 0 keeps the same alignment
      txFrameSyncIn = txMultiframeSyncIn ||
        ((r >= S + 255) && (r < S + 259));
      b = r - S;
      // Each slot carries its own number so idle forcing is visible
      txSerialIn = b < 0 ? 1'b0 : 1'(((b / 8) % 32) >> (7 - b % 8));
      t = r - S - 1;
      if (t == 100) flags[3:2] = {txMultiframeOut, txAlignFrameOut};
      if (t == 356) flags[1:0] = {txMultiframeOut, txAlignFrameOut};
      if (t == 4196) flags[4] = txAlignFrameOut;
      b = r - S - 6;
      q = b % 4096;
      p = b / 4096;
      if (b >= 0 && p < 3 && q < (p == 0 ? 512 : 256)) begin
        cap[p * 64 + q / 8] = {cap[p * 64 + q / 8][6:0],
          txLinePos | txLineNeg};
        if (q == (p == 0 ? 511 : 255)) passes++;
      end
    end
  end
  // ----------------------------------------------------------------
  // Receive side
  // ----------------------------------------------------------------
  initial begin
    {rxLineClock, rxLinePos, rxLineNeg, mark, prevFs, prevAf} = 6'h00;
    {sig, prevSig} = 16'h0000;
    pos = -1;
    hist = 7'h00;
    lfsr = 10'h001;
    {rxErr, rxCmp, n} = 96'h0;
    gap = -1;
    #137;
    forever begin
      #200 rxLineClock = 1'b1;
      #200 rxLineClock = 1'b0;
      hist = {hist[5:0], rxLinePos | rxLineNeg};
      n++;
      if (n > 20) begin
        rxCmp += 4;
        if (rxSerialOut !== hist[6]) begin
          rxErr++;
          $display("[ERR] rx_serial expected %b seen %b", hist[6], rxSerialOut);
        end
        if ((rxCasMfSyncOut | rxCrcMfSyncOut) === 1'b1 &&
            rxFrameSyncOut !== 1'b1) begin
          rxErr++;
          $display("[ERR] rx_mf_sync expected 0 seen 1");
        end
        if (rxFrameSyncOut === 1'b1 && !prevFs) begin
          if (gap > 0 && gap != 256) begin
            rxErr++;
            $display("[ERR] rx_frame_period expected 256 seen %0d", gap);
          end
          gap = 0;
        end
        if (gap >= 0) gap++;
        // Frame position taken from the first CAS multiframe mark
        if (pos >= 0) pos++;
        else if (rxCasMfSyncOut === 1'b1) pos = 4095;
        sl = (pos / 8) % 32;
        bt = pos % 8;
        fr = (pos / 256) % 16;
        if (pos >= 0 && sl == 0 && bt == 0) prevSig = sig;
        if (pos >= 0 && sl == 16) sig = {sig[6:0], hist[6]};
        e = 1'b0;
        if (bt >= 4 && sl == 16 + fr && fr != 0) e = sig[7 - bt];
        if (bt >= 4 && ((fr == 0 && sl == 15) || (fr > 1 && sl == fr - 1)))
          e = prevSig[11 - bt];
        if (pos >= 4352 && rxChanSignalingOut !== e) begin
          rxErr++;
          $display("[ERR] rx_signaling expected %b seen %b", e,
            rxChanSignalingOut);
        end
        if (pos >= 0 && pos % 256 != 0 &&
            rxAlignFrameOut !== prevAf) begin
          rxErr++;
          $display("[ERR] rx_align_edge expected %b seen %b", prevAf,
            rxAlignFrameOut);
        end
      end
      prevFs = rxFrameSyncOut === 1'b1;
      prevAf = rxAlignFrameOut;
      lfsr = {lfsr[8:0], lfsr[9] ^ lfsr[6]};
      if (lfsr[0]) mark = ~mark;
      rxLinePos = lfsr[0] & mark;
      rxLineNeg = lfsr[0] & ~mark;
    end
  end
endmodule

/* verification/e1_ts16_framer_tb.sv */
// Self-checking bench for the timeslot-16 framer block
`timescale 1ns/1ns
module e1_ts16_framer_tb;
  import e1_ts16_pkg::*;
  logic clk, rst_n, start, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic txClk, txSer, txExt, txFs, txMfs, txPos, txNeg, txMf, txAf;
  logic rxClk, rxPos, rxNeg, rxSer, rxSig, rxFs, rxCasMf, rxCrcMf, rxAf;
  logic [7:0] cap [160];
  logic [4:0] flags;
  logic [31:0] d;
  int passes, rxErr, rxCmp, fails, checks, cyc;
  // ----------------------------------------------------------------
  // Clock, reset, bus tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      fails++;
      $display("[ERR] timeout expected done seen hang");
      end_of_test();
    end
  end
  task automatic cmp(input string nm, input logic [31:0] e,
    input logic [31:0] s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    {d, rsp} = {rdata, rresp};
    rready <= 1'b0;
  endtask
  task automatic end_of_test();
    fails += rxErr;
    checks += rxCmp;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    for (int a = 0; a < 6; a++) begin
      rd(8'(4 * a));
      cmp("reset_value", 32'h0000_0000, d);
    end
    rd(OFS_STATUS);
    cmp("status_idle", 32'h0000_0000, d & 32'hFF00_0FFF);
    rd(8'h1C);
    cmp("unmapped_rresp", 32'(RESP_SLVERR), 32'(rsp));
    wr(8'h1C, 32'h0000_00FF);
    cmp("unmapped_bresp", 32'(RESP_SLVERR), 32'(rsp));
    wr(OFS_TX_EXTRA, 32'h0000_0006);
    rd(OFS_TX_EXTRA);
    cmp("extra_readback", 32'h0000_0006, d);
  endtask
  task automatic t_pin_idle();
    logic [7:0] e;
    wr(OFS_IDLE_0_7, 32'h0000_0021);
    wr(OFS_IDLE_16_23, 32'h0000_0001);
    wr(OFS_IDLE_24_31, 32'h0000_0080);
    start <= 1'b1;
    wait (passes >= 1);
    for (int k = 0; k < 64; k++) begin
      e = 8'(k % 32);
      if (e == 8'h05 || e == 8'h1F) e = IDLE_CODE;
      if (k == 16) e = 8'h0F;
      cmp("tx_slot", 32'(e), 32'(cap[k]));
    end
    cmp("tx_frame_flags", 32'h0000_000C, 32'(flags[3:0]));
  endtask
  task automatic t_reg_src();
    wr(OFS_CONTROL, 32'((1 << CTL_XREG) | (1 << CTL_ODD)));
    wr(OFS_IDLE_0_7, 32'h0000_0000);
    wait (passes >= 2);
    cmp("tx_extra_reg", 32'h0000_0006, 32'(cap[80]));
    cmp("tx_idle_off", 32'h0000_0005, 32'(cap[69]));
    cmp("tx_align_odd", 32'h0, 32'(flags[4]));
  endtask
  task automatic t_ccs();
    wr(OFS_CONTROL, 32'((1 << CTL_CCS) | (1 << CTL_HDB3)));
    rd(OFS_CONTROL);
    cmp("control_readback", 32'h0000_0009, d);
    wait (passes >= 3);
    cmp("tx_ccs_slot16", 32'h0000_0010, 32'(cap[144]));
  endtask
  // ----------------------------------------------------------------
  // Instances and main sequence
  // ----------------------------------------------------------------
  e1_ts16_framer e1_ts16_framer_i (.clk(clk), .rst_n(rst_n), .clkEn(1'b1),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .txLineClock(txClk), .txSerialIn(txSer),
    .txExtraBitIn(txExt), .txFrameSyncIn(txFs), .txMultiframeSyncIn(txMfs),
    .txLinePos(txPos), .txLineNeg(txNeg), .txMultiframeOut(txMf),
    .txAlignFrameOut(txAf), .rxLineClock(rxClk), .rxLinePos(rxPos),
    .rxLineNeg(rxNeg), .rxSerialOut(rxSer), .rxChanSignalingOut(rxSig),
    .rxFrameSyncOut(rxFs), .rxCasMfSyncOut(rxCasMf),
    .rxCrcMfSyncOut(rxCrcMf), .rxAlignFrameOut(rxAf));
  e1_line_model e1_line_model_i (.start(start), .txLineClock(txClk),
    .txSerialIn(txSer), .txExtraBitIn(txExt), .txFrameSyncIn(txFs),
    .txMultiframeSyncIn(txMfs), .txLinePos(txPos), .txLineNeg(txNeg),
    .txMultiframeOut(txMf), .txAlignFrameOut(txAf), .rxLineClock(rxClk),
    .rxLinePos(rxPos), .rxLineNeg(rxNeg), .rxSerialOut(rxSer),
    .rxFrameSyncOut(rxFs), .rxCasMfSyncOut(rxCasMf), .rxCrcMfSyncOut(rxCrcMf),
    .rxChanSignalingOut(rxSig), .rxAlignFrameOut(rxAf), .cap(cap),
    .flags(flags), .passes(passes), .rxErr(rxErr), .rxCmp(rxCmp));
  initial begin
    {rst_n, start, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {fails, checks, cyc} = 96'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_pin_idle();
    t_reg_src();
    t_ccs();
    end_of_test();
  end
endmodule
